// file: hdl/sqm_defs.svh
// Purpose: constants of the switch global control block
// Assumes: 200 MHz clock
// Notes: register index times four is the byte address
//
// Summary of operation
// - reserve bit set gives 48 high-priority buffers per queue; resets 0
// - scheme 00, the reset value, always sends high priority first
// - schemes 01, 10, 11 interleave high/low at 10/1, 5/1, 2/1
// - mirror match needs both ports in one mode, either port in other
// - mii bit 7 enables half-duplex back pressure; resets 0
// - mii bit 6 set gives half duplex, clear gives full duplex
// - duplex bit reset value is taken from its strap pin
// - mii bit 5 enables flow control; reset value from strap pin
// - mii bit 4 set gives 10Mbps, clear 100Mbps; reset from strap
// - bit 3 set replaces null VID with 12-bit port VID; resets 0
// - bits 2-0 hold storm budget bits 10:8; reset 000
// - storm period is 50ms at 100Mbps, 500ms at 10Mbps
// - storm budget bits 7:0 in next register, reset 0x4A
`ifndef SQM_DEFS_SVH
`define SQM_DEFS_SVH

`define SQM_IDX_RSV 6'h04
`define SQM_IDX_PSC 6'h05
`define SQM_IDX_MII 6'h06
`define SQM_IDX_BLO 6'h07

`define SQM_BIT_RSV 0
`define SQM_BIT_SCH_HI 3
`define SQM_BIT_SCH_LO 2
`define SQM_BIT_SNIFF 0
`define SQM_BIT_BP 7
`define SQM_BIT_HALF 6
`define SQM_BIT_FC 5
`define SQM_BIT_10M 4
`define SQM_BIT_NVID 3
`define SQM_BIT_BHI 2

`define SQM_RST_PSC 8'h00
`define SQM_RST_MII 8'h00
`define SQM_RST_BLO 8'h4A

`define SQM_RSV_BUFS 6'h30
`define SQM_RATIO_10 4'hA
`define SQM_RATIO_5 4'h5
`define SQM_RATIO_2 4'h2
`define SQM_NULL_VID 12'h000

`define SQM_RESP_OKAY 2'h0
`define SQM_RESP_SLVERR 2'h2

`define SQM_CLK_MHZ 200
`define SQM_PERIOD_100M_MS 50
`define SQM_PERIOD_10M_MS 500
`define SQM_MS_TO_CYC(ms) ((ms) * `SQM_CLK_MHZ * 1000)
`define SQM_STRAP_WAIT 3'h4

`endif

// file: hdl/sqm_global_ctrl.sv
// Purpose: global qos, mirror, switch mii and storm settings
// Assumes: AXI4-Lite slave, 8-bit registers in low byte lane
// Notes: bus is held off until the strap levels are loaded
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "sqm_defs.svh"
module sqm_global_ctrl import sqm_pkg::*; #(
	parameter int unsigned PERIOD_100M_CYC = `SQM_MS_TO_CYC(`SQM_PERIOD_100M_MS),
	parameter int unsigned PERIOD_10M_CYC = `SQM_MS_TO_CYC(`SQM_PERIOD_10M_MS)
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// strap pins
	input wire logic duplex_strap_pin,
	input wire logic flow_ctrl_strap_pin,
	input wire logic speed_strap_pin,
	// switch mii settings
	output logic mii_backpressure_en,
	output logic mii_half_duplex,
	output logic mii_flow_ctrl_en,
	output logic mii_speed_10m,
	// buffer reservation per output queue
	output logic [5:0] hi_reserved_bufs,
	// egress scheduler
	input wire logic hi_queued,
	input wire logic lo_queued,
	input wire logic pick_req,
	output logic pick_valid,
	output logic pick_hi,
	// mirroring
	input wire sqm_mirror_s mirror_chk,
	output logic mirror_hit,
	// null vid replacement
	input wire sqm_vid_s vid_in,
	output logic vid_out_valid,
	output logic [11:0] vid_out,
	// broadcast storm, port 4 is the switch mii port
	input wire logic [3:0] port_speed_10m,
	input wire logic [4:0] bcast_blk,
	output logic [4:0] bcast_drop
);
	//--------------------------------------------------
	// strap capture
	//--------------------------------------------------
	sqm_strap_s strap_lvl;
	sqm_strap_e st_r, st_nxt;
	logic [2:0] st_cnt_r, st_cnt_nxt;
	logic done;

	sqm_strap_sync u_sync (
		.clock(clock),
		.resetn(resetn),
		.pins({duplex_strap_pin, flow_ctrl_strap_pin, speed_strap_pin}),
		.level(strap_lvl)
	);

	always_comb begin
		st_nxt = st_r;
		st_cnt_nxt = st_cnt_r;
		unique case (st_r)
			SQM_ST_WAIT: begin
				st_cnt_nxt = 3'(st_cnt_r + 3'h1);
				if (st_cnt_r == `SQM_STRAP_WAIT) begin
					st_nxt = SQM_ST_LOAD;
				end
			end
			SQM_ST_LOAD: st_nxt = SQM_ST_DONE;
			SQM_ST_DONE: st_nxt = SQM_ST_DONE;
			default: st_nxt = SQM_ST_WAIT;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_r <= SQM_ST_WAIT;
			st_cnt_r <= 3'h0;
		end else begin
			st_r <= st_nxt;
			st_cnt_r <= st_cnt_nxt;
		end
	end

	assign done = (st_r == SQM_ST_DONE);

	//--------------------------------------------------
	// axi4-lite handshakes
	//--------------------------------------------------
	logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
	logic awh_r, awh_nxt, wh_r, wh_nxt, aw_take, w_take, ar_take, do_wr;
	logic [7:0] wa_r, wa_nxt, wd_r, wd_nxt, wa;
	logic ws_r, ws_nxt, ws;
	logic [7:0] wdat, rbyte;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;

	function automatic logic mapped(input logic [7:0] a);
		mapped = a[7:2] >= `SQM_IDX_RSV && a[7:2] <= `SQM_IDX_BLO;
	endfunction : mapped

	assign aw_take = s_axi_awvalid && awr_r;
	assign w_take = s_axi_wvalid && wr_r;
	assign ar_take = s_axi_arvalid && arr_r;
	assign do_wr = (awh_r || aw_take) && (wh_r || w_take) && !bv_r;
	assign wa = awh_r ? wa_r : s_axi_awaddr;
	assign wdat = wh_r ? wd_r : s_axi_wdata[7:0];
	assign ws = wh_r ? ws_r : s_axi_wstrb[0];

	always_comb begin
		awh_nxt = (awh_r || aw_take) && !do_wr;
		wh_nxt = (wh_r || w_take) && !do_wr;
		wa_nxt = aw_take ? s_axi_awaddr : wa_r;
		wd_nxt = w_take ? s_axi_wdata[7:0] : wd_r;
		ws_nxt = w_take ? s_axi_wstrb[0] : ws_r;
		bv_nxt = do_wr || (bv_r && !s_axi_bready);
		br_nxt = br_r;
		if (do_wr) begin
			br_nxt = mapped(wa) ? `SQM_RESP_OKAY : `SQM_RESP_SLVERR;
		end
		awr_nxt = done && !awh_nxt && !bv_nxt;
		wr_nxt = done && !wh_nxt && !bv_nxt;
		rv_nxt = ar_take || (rv_r && !s_axi_rready);
		arr_nxt = done && !rv_nxt;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		if (ar_take) begin
			rd_nxt = {24'h000000, rbyte};
			rr_nxt = mapped(s_axi_araddr) ? `SQM_RESP_OKAY : `SQM_RESP_SLVERR;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			awr_r <= 1'b0;
			wr_r <= 1'b0;
			bv_r <= 1'b0;
			arr_r <= 1'b0;
			rv_r <= 1'b0;
			awh_r <= 1'b0;
			wh_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 8'h00;
			ws_r <= 1'b0;
			br_r <= `SQM_RESP_OKAY;
			rr_r <= `SQM_RESP_OKAY;
			rd_r <= 32'h00000000;
		end else begin
			awr_r <= awr_nxt;
			wr_r <= wr_nxt;
			bv_r <= bv_nxt;
			arr_r <= arr_nxt;
			rv_r <= rv_nxt;
			awh_r <= awh_nxt;
			wh_r <= wh_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			br_r <= br_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
		end
	end

	//--------------------------------------------------
	// register file
	//--------------------------------------------------
	logic rsv_r, rsv_nxt;
	logic [7:0] psc_r, psc_nxt, mii_r, mii_nxt, blo_r, blo_nxt;
	logic [5:0] bufs_r, bufs_nxt;

	always_comb begin
		rsv_nxt = rsv_r;
		psc_nxt = psc_r;
		mii_nxt = mii_r;
		blo_nxt = blo_r;
		if (st_r == SQM_ST_LOAD) begin
			mii_nxt[`SQM_BIT_HALF] = strap_lvl.duplex;
			mii_nxt[`SQM_BIT_FC] = strap_lvl.flow_ctrl;
			mii_nxt[`SQM_BIT_10M] = strap_lvl.speed;
		end
		if (do_wr && ws) begin
			case (wa[7:2])
				`SQM_IDX_RSV: rsv_nxt = wdat[`SQM_BIT_RSV];
				`SQM_IDX_PSC: psc_nxt = wdat;
				`SQM_IDX_MII: mii_nxt = wdat;
				`SQM_IDX_BLO: blo_nxt = wdat;
				default: ;
			endcase
		end
		bufs_nxt = rsv_r ? `SQM_RSV_BUFS : 6'h00;
	end

	always_comb begin
		case (s_axi_araddr[7:2])
			`SQM_IDX_RSV: rbyte = {7'h00, rsv_r};
			`SQM_IDX_PSC: rbyte = psc_r;
			`SQM_IDX_MII: rbyte = mii_r;
			`SQM_IDX_BLO: rbyte = blo_r;
			default: rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rsv_r <= 1'b0;
			psc_r <= `SQM_RST_PSC;
			mii_r <= `SQM_RST_MII;
			blo_r <= `SQM_RST_BLO;
			bufs_r <= 6'h00;
		end else begin
			rsv_r <= rsv_nxt;
			psc_r <= psc_nxt;
			mii_r <= mii_nxt;
			blo_r <= blo_nxt;
			bufs_r <= bufs_nxt;
		end
	end

	//--------------------------------------------------
	// egress scheduler, mirror match, null vid
	//--------------------------------------------------
	sqm_scheme_e sch;
	logic [3:0] ratio, stk_r, stk_nxt;
	logic pv_r, pv_nxt, ph_r, ph_nxt, mh_r, mh_nxt, vv_r, vv_nxt;
	logic [11:0] vo_r, vo_nxt;

	assign sch = sqm_scheme_e'(psc_r[`SQM_BIT_SCH_HI:`SQM_BIT_SCH_LO]);

	always_comb begin
		unique case (sch)
			SQM_SCH_STRICT: ratio = 4'h0;
			SQM_SCH_10TO1: ratio = `SQM_RATIO_10;
			SQM_SCH_5TO1: ratio = `SQM_RATIO_5;
			SQM_SCH_2TO1: ratio = `SQM_RATIO_2;
		endcase
		stk_nxt = stk_r;
		pv_nxt = 1'b0;
		ph_nxt = ph_r;
		if (pick_req && (hi_queued || lo_queued)) begin
			pv_nxt = 1'b1;
			if (sch == SQM_SCH_STRICT) begin
				ph_nxt = hi_queued;
			end else begin
				ph_nxt = hi_queued && (!lo_queued || stk_r < ratio);
			end
			if (!ph_nxt) begin
				stk_nxt = 4'h0;
			end else if (lo_queued && sch != SQM_SCH_STRICT) begin
				stk_nxt = 4'(stk_r + 4'h1);
			end
		end
		mh_nxt = mirror_chk.valid && (psc_r[`SQM_BIT_SNIFF] ?
			(mirror_chk.src_match && mirror_chk.dst_match) :
			(mirror_chk.src_match || mirror_chk.dst_match));
		vv_nxt = vid_in.valid;
		vo_nxt = vo_r;
		if (vid_in.valid) begin
			vo_nxt = (mii_r[`SQM_BIT_NVID] && vid_in.vid == `SQM_NULL_VID) ? vid_in.pvid : vid_in.vid;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stk_r <= 4'h0;
			pv_r <= 1'b0;
			ph_r <= 1'b0;
			mh_r <= 1'b0;
			vv_r <= 1'b0;
			vo_r <= 12'h000;
		end else begin
			stk_r <= stk_nxt;
			pv_r <= pv_nxt;
			ph_r <= ph_nxt;
			mh_r <= mh_nxt;
			vv_r <= vv_nxt;
			vo_r <= vo_nxt;
		end
	end

	//--------------------------------------------------
	// storm period dividers and metering
	//--------------------------------------------------
	logic [26:0] pf_r, pf_nxt, ps_r, ps_nxt;
	logic tf_r, tf_nxt, ts_r, ts_nxt;

	always_comb begin
		tf_nxt = (pf_r == 27'(PERIOD_100M_CYC - 1));
		ts_nxt = (ps_r == 27'(PERIOD_10M_CYC - 1));
		pf_nxt = tf_nxt ? 27'h0000000 : 27'(pf_r + 27'h0000001);
		ps_nxt = ts_nxt ? 27'h0000000 : 27'(ps_r + 27'h0000001);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pf_r <= 27'h0000000;
			ps_r <= 27'h0000000;
			tf_r <= 1'b0;
			ts_r <= 1'b0;
		end else begin
			pf_r <= pf_nxt;
			ps_r <= ps_nxt;
			tf_r <= tf_nxt;
			ts_r <= ts_nxt;
		end
	end

	sqm_storm_meter u_storm (
		.clock(clock),
		.resetn(resetn),
		.tick_100m(tf_r),
		.tick_10m(ts_r),
		.budget({mii_r[`SQM_BIT_BHI:0], blo_r}),
		.speed_10m({mii_r[`SQM_BIT_10M], port_speed_10m}),
		.blk(bcast_blk),
		.drop(bcast_drop)
	);

	//--------------------------------------------------
	// outputs
	//--------------------------------------------------
	assign s_axi_awready = awr_r;
	assign s_axi_wready = wr_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rresp = rr_r;
	assign s_axi_rdata = rd_r;
	assign mii_backpressure_en = mii_r[`SQM_BIT_BP];
	assign mii_half_duplex = mii_r[`SQM_BIT_HALF];
	assign mii_flow_ctrl_en = mii_r[`SQM_BIT_FC];
	assign mii_speed_10m = mii_r[`SQM_BIT_10M];
	assign hi_reserved_bufs = bufs_r;
	assign pick_valid = pv_r;
	assign pick_hi = ph_r;
	assign mirror_hit = mh_r;
	assign vid_out_valid = vv_r;
	assign vid_out = vo_r;

	//--------------------------------------------------
	// checks
	//--------------------------------------------------
	sequence s_load;
		st_r == SQM_ST_LOAD;
	endsequence
	sequence s_strap_held;
		mii_r[`SQM_BIT_HALF] == $past(strap_lvl.duplex) && mii_r[`SQM_BIT_FC] == $past(strap_lvl.flow_ctrl);
	endsequence

	a_reserve_bufs: assert property (@(posedge clock) disable iff (!resetn)
		##1 bufs_r == ($past(rsv_r) ? `SQM_RSV_BUFS : 6'h00))
		else $error("reserved buffer count wrong");
	a_strict_first: assert property (@(posedge clock) disable iff (!resetn)
		pick_req && hi_queued && sch == SQM_SCH_STRICT |=> pv_r && ph_r)
		else $error("strict scheme did not pick high");
	a_ratio_bound: assert property (@(posedge clock) disable iff (!resetn)
		pick_req && hi_queued && lo_queued && sch != SQM_SCH_STRICT && stk_r >= ratio |=> pv_r && !ph_r)
		else $error("weighted ratio exceeded");
	a_mirror_both: assert property (@(posedge clock) disable iff (!resetn)
		mirror_chk.valid && psc_r[`SQM_BIT_SNIFF] |=> mh_r == $past(mirror_chk.src_match && mirror_chk.dst_match))
		else $error("both-port mirror match wrong");
	a_mirror_either: assert property (@(posedge clock) disable iff (!resetn)
		mirror_chk.valid && !psc_r[`SQM_BIT_SNIFF] |=> mh_r == $past(mirror_chk.src_match || mirror_chk.dst_match))
		else $error("either-port mirror match wrong");
	a_strap_load: assert property (@(posedge clock) disable iff (!resetn)
		s_load |=> s_strap_held and mii_r[`SQM_BIT_10M] == $past(strap_lvl.speed))
		else $error("strap values not loaded");
	a_null_vid: assert property (@(posedge clock) disable iff (!resetn)
		vid_in.valid && vid_in.vid == `SQM_NULL_VID && mii_r[`SQM_BIT_NVID] |=> vv_r && vo_r == $past(vid_in.pvid))
		else $error("null vid not replaced");
	a_budget_reset: assert property (@(posedge clock) disable iff (!resetn)
		!done |-> blo_r == `SQM_RST_BLO && mii_r[`SQM_BIT_BHI:0] == 3'h0 && !mii_r[`SQM_BIT_BP])
		else $error("budget or back pressure reset wrong");
	a_period_fast: assert property (@(posedge clock) disable iff (!resetn)
		tf_r |-> $past(pf_r) == 27'(PERIOD_100M_CYC - 1))
		else $error("100M period tick misplaced");
endmodule : sqm_global_ctrl

// file: hdl/sqm_pkg.sv
// Purpose: types of the switch global control block
// Assumes: nothing
// Notes: constants live in sqm_defs.svh
package sqm_pkg;
	typedef enum logic [1:0] {
		SQM_SCH_STRICT = 2'h0,
		SQM_SCH_10TO1 = 2'h1,
		SQM_SCH_5TO1 = 2'h2,
		SQM_SCH_2TO1 = 2'h3
	} sqm_scheme_e;
	typedef enum logic [1:0] {
		SQM_ST_WAIT = 2'h0,
		SQM_ST_LOAD = 2'h1,
		SQM_ST_DONE = 2'h3
	} sqm_strap_e;
	typedef struct packed {
		logic valid;
		logic src_match;
		logic dst_match;
	} sqm_mirror_s;
	typedef struct packed {
		logic valid;
		logic [11:0] vid;
		logic [11:0] pvid;
	} sqm_vid_s;
	typedef struct packed {
		logic duplex;
		logic flow_ctrl;
		logic speed;
	} sqm_strap_s;
	typedef logic [10:0] sqm_budget_t;
endpackage : sqm_pkg

// file: hdl/sqm_storm_meter.sv
// Purpose: per-port broadcast storm metering
// Assumes: one pulse per 64-byte broadcast block
// Notes: counter saturates so a long storm cannot wrap under budget
`timescale 1ns/10ps
module sqm_storm_meter import sqm_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// period ticks and budget
	input wire logic tick_100m,
	input wire logic tick_10m,
	input wire sqm_budget_t budget,
	// ports
	input wire logic [4:0] speed_10m,
	input wire logic [4:0] blk,
	output logic [4:0] drop
);
	genvar i;
	generate
		for (i = 0; i < 5; i++) begin : g_port
			logic [11:0] cnt_r, cnt_nxt;
			logic drop_r, drop_nxt, tick;

			assign tick = speed_10m[i] ? tick_10m : tick_100m;

			always_comb begin
				cnt_nxt = cnt_r;
				drop_nxt = drop_r;
				if (tick) begin
					cnt_nxt = {11'h000, blk[i]};
					drop_nxt = 1'b0;
				end else if (blk[i] && cnt_r != 12'hFFF) begin
					cnt_nxt = 12'(cnt_r + 12'h001);
				end
				if (cnt_nxt > {1'b0, budget}) begin
					drop_nxt = 1'b1;
				end
			end

			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					cnt_r <= 12'h000;
					drop_r <= 1'b0;
				end else begin
					cnt_r <= cnt_nxt;
					drop_r <= drop_nxt;
				end
			end

			assign drop[i] = drop_r;

			a_drop_holds: assert property (@(posedge clock) disable iff (!resetn)
				drop_r && !tick |=> drop_r)
				else $error("storm drop released inside period");
			a_drop_sets: assert property (@(posedge clock) disable iff (!resetn)
				!tick && cnt_nxt > {1'b0, budget} |=> drop_r)
				else $error("storm drop not set over budget");
		end
	endgenerate
endmodule : sqm_storm_meter

// file: hdl/sqm_strap_sync.sv
// Purpose: three-stage synchroniser for strap pins
// Assumes: pins are asynchronous to clock
// Notes: output moves only when stages two and three agree
`timescale 1ns/10ps
module sqm_strap_sync import sqm_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// pins and filtered level
	input wire sqm_strap_s pins,
	output sqm_strap_s level
);
	logic [2:0] q1_r, q2_r, q3_r, lvl_r, lvl_nxt;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_bit
			always_comb begin
				lvl_nxt[i] = (q2_r[i] == q3_r[i]) ? q3_r[i] : lvl_r[i];
			end
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					q1_r[i] <= 1'b0;
					q2_r[i] <= 1'b0;
					q3_r[i] <= 1'b0;
					lvl_r[i] <= 1'b0;
				end else begin
					q1_r[i] <= pins[i];
					q2_r[i] <= q1_r[i];
					q3_r[i] <= q2_r[i];
					lvl_r[i] <= lvl_nxt[i];
				end
			end
		end
	endgenerate

	assign level = lvl_r;
endmodule : sqm_strap_sync

// file: tb/sqm_mac_model.sv
// Purpose: far-side model of the partner on the switch mii port
// Assumes: strap levels are fixed from power-up on
// Notes: a level of 0 stands for the internal pull-down
`timescale 1ns/10ps
module sqm_mac_model import sqm_pkg::*; (
	// strap choice
	input wire sqm_strap_s strap_cfg,
	// pins sampled at reset
	output logic duplex_strap_pin,
	output logic flow_ctrl_strap_pin,
	output logic speed_strap_pin
);
	// partner pulls up only the settings it wants, the rest stay pulled down
	assign duplex_strap_pin = strap_cfg.duplex;
	assign flow_ctrl_strap_pin = strap_cfg.flow_ctrl;
	assign speed_strap_pin = strap_cfg.speed;
endmodule : sqm_mac_model

// file: tb/switch_qos_mii_global_ctrl_tb.sv
// Purpose: self-checking bench of the switch global control block
// Assumes: storm periods shortened to 64 and 640 cycles
// Notes: bus waits are bounded, a watchdog ends a hang
`timescale 1ns/10ps
module switch_qos_mii_global_ctrl_tb import sqm_pkg::*;;
	logic clock = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0, port_speed_10m = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic duplex_strap_pin, flow_ctrl_strap_pin, speed_strap_pin;
	logic mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10m;
	logic [5:0] hi_reserved_bufs;
	logic hi_queued = '0, lo_queued = '0, pick_req = '0, pick_valid, pick_hi, mirror_hit, vid_out_valid;
	sqm_mirror_s mirror_chk = '0;
	sqm_vid_s vid_in = '0;
	logic [11:0] vid_out, o_vid;
	logic [4:0] bcast_blk = '0, bcast_drop;
	sqm_strap_s strap = '0;
	int err_count = 0, samples_checked = 0;
	logic o_pv, o_hi, o_mir, o_vv;
	logic [31:0] rd;

	sqm_global_ctrl #(.PERIOD_100M_CYC(64), .PERIOD_10M_CYC(640)) sqm_global_ctrl_i (.clock, .resetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duplex_strap_pin,
		.flow_ctrl_strap_pin, .speed_strap_pin, .mii_backpressure_en, .mii_half_duplex, .mii_flow_ctrl_en,
		.mii_speed_10m, .hi_reserved_bufs, .hi_queued, .lo_queued, .pick_req, .pick_valid, .pick_hi,
		.mirror_chk, .mirror_hit, .vid_in, .vid_out_valid, .vid_out, .port_speed_10m, .bcast_blk, .bcast_drop);
	sqm_mac_model sqm_mac_model_i (.strap_cfg(strap), .duplex_strap_pin, .flow_ctrl_strap_pin, .speed_strap_pin);

	always #2.5 clock = ~clock;

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	function automatic logic exp_mir(logic m, logic s, logic d);
		return m ? (s & d) : (s | d);
	endfunction : exp_mir

	function automatic logic [11:0] exp_vid(logic m, sqm_vid_s v);
		return (m && v.vid == 12'h000) ? v.pvid : v.vid;
	endfunction : exp_vid

	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st, output logic [1:0] r);
		int n;
		logic ad;
		logic wd;
		n = 0;
		ad = 0;
		wd = 0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clock);
			n++;
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'h0;
			end
		end while (s_axi_bvalid !== 1'h1 && n < 200);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		chk("write done", n < 200, 1);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ad;
		n = 0;
		ad = 0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clock);
			n++;
			if (!ad && s_axi_arready) begin
				ad = 1;
				s_axi_arvalid <= 1'h0;
			end
		end while (s_axi_rvalid !== 1'h1 && n < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		chk("read done", n < 200, 1);
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		axi_wr(a, d, 4'hF, rs);
		chk("bresp", rs, 2'h0);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rd, rs);
		chk($sformatf("reg %h", a), {rs, rd[29:0]}, {2'h0, e[29:0]});
		chk("rdata top", rd[31:30], 2'h0);
	endtask : rchk

	// one request on the pick, mirror and vid inputs, answers sampled a cycle later
	task automatic pulse(input logic pr, input sqm_mirror_s m, input sqm_vid_s v);
		pick_req <= pr;
		mirror_chk <= m;
		vid_in <= v;
		@(posedge clock);
		pick_req <= 1'h0;
		mirror_chk <= '0;
		vid_in <= '0;
		@(posedge clock);
		o_pv = pick_valid;
		o_hi = pick_hi;
		o_mir = mirror_hit;
		o_vv = vid_out_valid;
		o_vid = vid_out;
	endtask : pulse

	task automatic wdrop(input int p, input logic l, output int n);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (bcast_drop[p] !== l && n < 2000);
	endtask : wdrop

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n, a, b, k, s;
		logic [7:0] v;
		sqm_vid_s vv;
		void'($urandom(32'h68662C18));
		strap = 3'($urandom);
		repeat (5) @(posedge clock);
		resetn <= 1'h1;
		rchk(8'h10, 32'h0);
		rchk(8'h14, 32'h0);
		rchk(8'h18, {24'h0, 1'h0, strap.duplex, strap.flow_ctrl, strap.speed, 4'h0});
		rchk(8'h1C, 32'h4A);
		axi_rd(8'h20, rd, rs);
		chk("unmapped rresp", rs, 2'h2);
		chk("unmapped rdata", rd, 32'h0);
		axi_wr(8'h00, 8'hFF, 4'hF, rs);
		chk("unmapped write", rs, 2'h2);
		axi_wr(8'h1C, 8'h55, 4'h0, rs);
		chk("no strobe bresp", rs, 2'h0);
		rchk(8'h1C, 32'h4A);
		wr(8'h10, 8'hFF);
		rchk(8'h10, 32'h1);
		chk("reserved bufs", hi_reserved_bufs, 6'h30);
		wr(8'h10, 8'h00);
		rchk(8'h10, 32'h0);
		chk("reserved bufs", hi_reserved_bufs, 6'h00);
		for (k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			wr(8'h18, v);
			rchk(8'h18, {24'h0, v});
			chk("mii", {mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10m}, v[7:4]);
		end
		wr(8'h14, 8'hF3);
		rchk(8'h14, 32'hF3);
		// priority queueing in use, so software reserves the buffers
		wr(8'h10, 8'h01);
		hi_queued <= 1'h1;
		lo_queued <= 1'h1;
		for (s = 0; s < 4; s++) begin
			wr(8'h14, 8'(s << 2));
			n = (s == 1) ? 10 : (s == 2) ? 5 : (s == 3) ? 2 : 0;
			k = 0;
			do begin
				pulse(1'h1, '0, '0);
				k++;
			end while (n > 0 && o_hi !== 1'h0 && k < 13);
			chk("strict", {o_pv, o_hi}, (n == 0) ? 2'h3 : 2'h2);
			repeat (2) begin
				repeat ((n == 0) ? 8 : n) begin
					pulse(1'h1, '0, '0);
					chk("pick high", {o_pv, o_hi}, 2'h3);
				end
				pulse(1'h1, '0, '0);
				chk("pick low", {o_pv, o_hi}, (n == 0) ? 2'h3 : 2'h2);
			end
		end
		hi_queued <= 1'h0;
		pulse(1'h1, '0, '0);
		chk("only low", {o_pv, o_hi}, 2'h2);
		lo_queued <= 1'h0;
		pulse(1'h1, '0, '0);
		chk("empty", o_pv, 1'h0);
		for (s = 0; s < 2; s++) begin
			wr(8'h14, 8'(s));
			for (k = 0; k < 4; k++) begin
				pulse(1'h0, {1'h1, k[1], k[0]}, '0);
				chk("mirror", o_mir, exp_mir(s[0], k[1], k[0]));
			end
		end
		for (s = 0; s < 2; s++) begin
			wr(8'h18, {4'h0, s[0], 3'h0});
			for (k = 0; k < 4; k++) begin
				vv.valid = 1'h1;
				vv.vid = k[0] ? 12'($urandom_range(1, 4095)) : 12'h000;
				vv.pvid = 12'($urandom);
				pulse(1'h0, '0, vv);
				chk("vid", {o_vv, o_vid}, {1'h1, exp_vid(s[0], vv)});
			end
		end
		wr(8'h18, 8'h00);
		wr(8'h1C, 8'h02);
		port_speed_10m <= 4'h8;
		bcast_blk <= 5'h0A;
		wdrop(1, 1'h1, n);
		wdrop(1, 1'h0, n);
		wdrop(1, 1'h1, a);
		wdrop(1, 1'h0, b);
		chk("period 100m", a + b, 64);
		bcast_blk <= 5'h1F;
		@(posedge clock);
		@(posedge clock);
		bcast_blk <= 5'h1E;
		@(posedge clock);
		bcast_blk <= 5'h0A;
		repeat (3) @(posedge clock);
		chk("drop at budget", bcast_drop[0], 1'h0);
		chk("drop over budget", bcast_drop[2], 1'h1);
		chk("mii port drop", bcast_drop[4], 1'h1);
		wdrop(3, 1'h1, n);
		wdrop(3, 1'h0, n);
		wdrop(3, 1'h1, a);
		wdrop(3, 1'h0, b);
		chk("period 10m", a + b, 640);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clock);
		chk("watchdog", 0, 1);
		summarize();
	end
endmodule : switch_qos_mii_global_ctrl_tb
